// >>> core/pms_device.sv
// What this block does
// - Controller drives select and clock; device data
// - Frame is fixed 80 bits, no header
// - Mode 0, tolerant of same-edge capture
// - Controller keeps shift clock near 1 MHz
// - Select rising aborts the frame
// - Samples go out MSB first
// - Data output released when not transmitting
// - Single-shot: select falling starts conversion
// - Controller spaces selects by ADC time
// - First bit at select fall, then clock falls
// - Frame carries the sample before latest
// - Config on management bus, both concurrent
// - Current times input voltage gives power
// - Power accumulated, counted, rollover counted
// - Energy read snapshots count coherently
// - Average over 2^N samples, N 0..7
// - Single shot averages then reports once
// - Continuous mode keeps sampling, latest shown
// - Convert bit starts at transfer end
// - Peak holders keep highest since clear
// - Current signed, plus/minus sense span
// - Voltage source input, output or both
// - Temperature slot every 6 ms, result 12 ms
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "pms_defines.svh"
module pms_device #(
    parameter int TEMP_PERIOD_CYC = `PMS_TEMP_PERIOD_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Management bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // ADC
    output logic adc_req,
    output logic adc_temp,
    input wire logic adc_done,
    input wire logic [15:0] adc_current,
    input wire logic [15:0] adc_vin,
    input wire logic [15:0] adc_output_voltage_pin,
    input wire logic [15:0] adc_temperature,
    // Stream link
    pms_link_if.device link
);

    pms_pkg::pms_dev_state_t r_reg;
    pms_pkg::pms_dev_state_t r_next;

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign adc_req = r_reg.adc_req;
    assign adc_temp = r_reg.adc_temp;
    assign link.serial_data_out = r_reg.dout;
    assign link.serial_data_oe = r_reg.oe;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic sel_fall;
        logic sel_rise;
        logic clk_fall;
        logic setup;
        logic access_wr;
        logic signed [31:0] pwr;
        logic signed [22:0] si;
        logic [22:0] sv;
        logic [22:0] so;
        logic signed [38:0] sp;
        logic [32:0] esum;
        logic [15:0] ai;
        logic [15:0] av;
        logic [15:0] ao;
        logic [31:0] ap;
        logic [79:0] frame;
        sel_fall = 1'b0;
        sel_rise = 1'b0;
        clk_fall = 1'b0;
        setup = 1'b0;
        access_wr = 1'b0;
        pwr = '0;
        si = '0;
        sv = '0;
        so = '0;
        sp = '0;
        esum = '0;
        ai = '0;
        av = '0;
        ao = '0;
        ap = '0;
        frame = '0;
        r_next = r_reg;
        r_next.adc_req = 1'b0;
        r_next.pready = 1'b1;

        // Link inputs: first stage feeds only the second
        r_next.sel_s1 = link.serial_select_n;
        r_next.sel_s2 = r_reg.sel_s1;
        r_next.sel_s3 = r_reg.sel_s2;
        r_next.clk_s1 = link.serial_shift_clock;
        r_next.clk_s2 = r_reg.clk_s1;
        r_next.clk_s3 = r_reg.clk_s2;
        sel_fall = r_reg.sel_s3 & ~r_reg.sel_s2;
        sel_rise = ~r_reg.sel_s3 & r_reg.sel_s2;
        clk_fall = r_reg.clk_s3 & ~r_reg.clk_s2;

        // Management bus, zero wait states
        setup = psel & ~penable;
        access_wr = psel & penable & pwrite;
        if (setup) begin
            r_next.pslverr = 1'b0;
            case (paddr)
                `PMS_DEV_CONFIG: r_next.prdata = {26'h0, r_reg.vsel, r_reg.avg_n, r_reg.cont};
                `PMS_DEV_CONTROL: r_next.prdata = {31'h0, r_reg.conv_pend};
                `PMS_DEV_CURRENT: r_next.prdata = {{16{r_reg.res_i[15]}}, r_reg.res_i};
                `PMS_DEV_VIN: r_next.prdata = {16'h0, r_reg.res_v};
                `PMS_DEV_OUTPUT_VOLTAGE_PIN: r_next.prdata = {16'h0, r_reg.res_o};
                `PMS_DEV_POWER: r_next.prdata = r_reg.res_p;
                `PMS_DEV_ENERGY: begin
                    r_next.prdata = r_reg.energy;
                    r_next.snap_cnt = r_reg.e_cnt;
                end
                `PMS_DEV_ENERGY_CNT: r_next.prdata = {8'h0, r_reg.snap_cnt};
                `PMS_DEV_ROLLOVER: r_next.prdata = {24'h0, r_reg.e_roll};
                `PMS_DEV_PEAK_I: r_next.prdata = {{16{r_reg.pk_i[15]}}, r_reg.pk_i};
                `PMS_DEV_PEAK_INPUT_VOLTAGE_CMD: r_next.prdata = {16'h0, r_reg.pk_v};
                `PMS_DEV_PEAK_OUTPUT_VOLTAGE_CMD: r_next.prdata = {16'h0, r_reg.pk_o};
                `PMS_DEV_PEAK_P: r_next.prdata = r_reg.pk_p;
                `PMS_DEV_PEAK_T: r_next.prdata = {16'h0, r_reg.pk_t};
                `PMS_DEV_TEMP: r_next.prdata = {16'h0, r_reg.res_t};
                default: begin
                    r_next.prdata = 32'h0000_0000;
                    r_next.pslverr = 1'b1;
                end
            endcase
        end
        if (access_wr && paddr == `PMS_DEV_CONFIG) begin
            r_next.cont = pwdata[`PMS_CFG_CONT];
            r_next.avg_n = pwdata[`PMS_CFG_AVG_LO +: 3];
            r_next.vsel = pwdata[`PMS_CFG_VSEL_LO +: 2];
        end
        // Conversion is armed only as the access completes, like a stop condition
        if (access_wr && paddr == `PMS_DEV_CONTROL) begin
            if (pwdata[`PMS_CTL_CONVERT] && !r_reg.cont) begin
                r_next.conv_pend = 1'b1;
            end
            if (pwdata[`PMS_CTL_CLR_PEAK]) begin
                r_next.pk_i = 16'h8000;
                r_next.pk_v = 16'h0000;
                r_next.pk_o = 16'h0000;
                r_next.pk_p = 32'h8000_0000;
                r_next.pk_t = 16'h0000;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Temperature slot timer
        if (r_reg.tmr >= 24'(TEMP_PERIOD_CYC - 1)) begin
            r_next.tmr = 24'h00_0000;
            r_next.temp_due = 1'b1;
        end else begin
            r_next.tmr = r_reg.tmr + 24'h00_0001;
        end

        // ADC sequencer
        case (r_reg.st)
            pms_pkg::PMS_ADC_IDLE: begin
                if (r_reg.temp_due) begin
                    r_next.temp_due = 1'b0;
                    r_next.adc_req = 1'b1;
                    r_next.adc_temp = 1'b1;
                    r_next.st = pms_pkg::PMS_ADC_TEMP;
                end else if (r_reg.cont || r_reg.conv_pend) begin
                    r_next.adc_req = 1'b1;
                    r_next.adc_temp = 1'b0;
                    r_next.st = pms_pkg::PMS_ADC_SAMPLE;
                end
            end
            pms_pkg::PMS_ADC_TEMP: begin
                if (adc_done) begin
                    r_next.temp_phase = ~r_reg.temp_phase;
                    // Two slots per result: slow diode sequence
                    if (r_reg.temp_phase) begin
                        r_next.res_t = adc_temperature;
                        if (adc_temperature > r_next.pk_t) begin
                            r_next.pk_t = adc_temperature;
                        end
                    end
                    r_next.st = pms_pkg::PMS_ADC_IDLE;
                end
            end
            pms_pkg::PMS_ADC_SAMPLE: begin
                if (adc_done) begin
                    pwr = $signed(adc_current) * $signed({1'b0, adc_vin[14:0]});
                    esum = {1'b0, r_reg.energy} + {1'b0, pwr};
                    r_next.energy = esum[31:0];
                    r_next.e_cnt = r_reg.e_cnt + 24'h00_0001;
                    if (esum[32]) begin
                        r_next.e_roll = r_reg.e_roll + 8'h01;
                    end
                    si = r_reg.sum_i + 23'(signed'(adc_current));
                    sv = r_reg.sum_v + {7'h00, adc_vin};
                    so = r_reg.sum_o + {7'h00, adc_output_voltage_pin};
                    sp = r_reg.sum_p + 39'(pwr);
                    if (r_reg.n_cnt == 8'((9'h001 << r_reg.avg_n) - 9'h001)) begin
                        ai = 16'(si >>> r_reg.avg_n);
                        av = 16'(sv >> r_reg.avg_n);
                        ao = 16'(so >> r_reg.avg_n);
                        ap = 32'(sp >>> r_reg.avg_n);
                        r_next.res_i = ai;
                        r_next.res_p = ap;
                        if (r_reg.vsel[`PMS_VSEL_VIN] || r_reg.vsel == 2'b00) begin
                            r_next.res_v = av;
                            // Compared with the cleared value, so a sample landing on a clear is kept
                            if (av > r_next.pk_v) r_next.pk_v = av;
                        end
                        if (r_reg.vsel[`PMS_VSEL_OUTPUT_VOLTAGE_PIN]) begin
                            r_next.res_o = ao;
                            if (ao > r_next.pk_o) r_next.pk_o = ao;
                        end
                        if ($signed(ai) > $signed(r_next.pk_i)) r_next.pk_i = ai;
                        if ($signed(ap) > $signed(r_next.pk_p)) r_next.pk_p = ap;
                        // One layout whatever the selection, tail padded with zeros
                        frame = {ai, r_next.res_v, r_next.res_o, r_reg.res_t, 16'h0000};
                        r_next.frame_prev = r_reg.frame_cur;
                        r_next.frame_cur = frame;
                        r_next.n_cnt = 8'h00;
                        r_next.sum_i = '0;
                        r_next.sum_v = '0;
                        r_next.sum_o = '0;
                        r_next.sum_p = '0;
                        // A convert written in the same cycle starts the next run
                        if (!(access_wr && paddr == `PMS_DEV_CONTROL && pwdata[`PMS_CTL_CONVERT])) begin
                            r_next.conv_pend = 1'b0;
                        end
                    end else begin
                        r_next.n_cnt = r_reg.n_cnt + 8'h01;
                        r_next.sum_i = si;
                        r_next.sum_v = sv;
                        r_next.sum_o = so;
                        r_next.sum_p = sp;
                    end
                    r_next.st = pms_pkg::PMS_ADC_IDLE;
                end
            end
            default: r_next.st = pms_pkg::PMS_ADC_IDLE;
        endcase

        ////////////////////////////////////////////////////////////////////////
        // Stream port; abort beats a coinciding shift
        if (sel_rise) begin
            r_next.active = 1'b0;
            r_next.oe = 1'b0;
        end else if (sel_fall) begin
            r_next.active = 1'b1;
            r_next.oe = 1'b1;
            r_next.frame_sh = r_reg.frame_prev;
            r_next.dout = r_reg.frame_prev[`PMS_FRAME_BITS - 1];
            r_next.bits_left = 7'(`PMS_FRAME_BITS - 1);
            if (!r_reg.cont) begin
                r_next.conv_pend = 1'b1;
            end
        end else if (clk_fall && r_reg.active) begin
            // Data moves on the falling edge, so it is stable at either capture edge
            if (r_reg.bits_left != 7'h00) begin
                r_next.frame_sh = {r_reg.frame_sh[`PMS_FRAME_BITS - 2:0], 1'b0};
                r_next.dout = r_reg.frame_sh[`PMS_FRAME_BITS - 2];
                r_next.bits_left = r_reg.bits_left - 7'h01;
            end else begin
                r_next.active = 1'b0;
                r_next.oe = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.sel_s1 <= 1'b1;
            r_reg.sel_s2 <= 1'b1;
            r_reg.sel_s3 <= 1'b1;
            r_reg.pk_i <= 16'h8000;
            r_reg.pk_p <= 32'h8000_0000;
        end else begin
            r_reg <= r_next;
        end
    end

endmodule : pms_device

// >>> core/pms_defines.svh
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH

// Clock and timing
`define PMS_CLK_MHZ 50
`define PMS_TEMP_PERIOD_US 6000
`define PMS_TEMP_PERIOD_CYC (`PMS_TEMP_PERIOD_US * `PMS_CLK_MHZ)
`define PMS_SCLK_MAX_KHZ 1000
`define PMS_SCLK_HALF_CYC ((`PMS_CLK_MHZ * 1000 + 2 * `PMS_SCLK_MAX_KHZ - 1) / (2 * `PMS_SCLK_MAX_KHZ))
`define PMS_ADC_MAX_US 165
`define PMS_FRAME_GAP_CYC (`PMS_ADC_MAX_US * `PMS_CLK_MHZ)

// Frame
`define PMS_FRAME_BITS 80
`define PMS_SAMPLE_BITS 16

// Device register offsets
`define PMS_DEV_CONFIG 8'h00
`define PMS_DEV_CONTROL 8'h04
`define PMS_DEV_CURRENT 8'h08
`define PMS_DEV_VIN 8'h0c
`define PMS_DEV_OUTPUT_VOLTAGE_PIN 8'h10
`define PMS_DEV_POWER 8'h14
`define PMS_DEV_ENERGY 8'h18
`define PMS_DEV_ENERGY_CNT 8'h1c
`define PMS_DEV_ROLLOVER 8'h20
`define PMS_DEV_PEAK_I 8'h24
`define PMS_DEV_PEAK_INPUT_VOLTAGE_CMD 8'h28
`define PMS_DEV_PEAK_OUTPUT_VOLTAGE_CMD 8'h2c
`define PMS_DEV_PEAK_P 8'h30
`define PMS_DEV_PEAK_T 8'h34
`define PMS_DEV_TEMP 8'h38

// Config fields: bit0 continuous, bits3:1 averaging exponent, bits5:4 voltage select
`define PMS_CFG_CONT 0
`define PMS_CFG_AVG_LO 1
`define PMS_CFG_VSEL_LO 4
`define PMS_VSEL_VIN 0
`define PMS_VSEL_OUTPUT_VOLTAGE_PIN 1
// Control fields
`define PMS_CTL_CONVERT 0
`define PMS_CTL_CLR_PEAK 1

// Host register offsets
`define PMS_HST_CONTROL 8'h00
`define PMS_HST_STATUS 8'h04
`define PMS_HST_RX0 8'h08
`define PMS_HST_RX1 8'h0c
`define PMS_HST_RX2 8'h10
// Host fields: control bit0 start, bits14:8 bit count; status bit0 busy, bit1 done
`define PMS_HCTL_START 0
`define PMS_HCTL_NBITS_LO 8
`define PMS_HST_BUSY 0
`define PMS_HST_DONE 1

`endif

// >>> core/pms_pkg.sv
package pms_pkg;

typedef enum logic [1:0] {
    PMS_ADC_IDLE = 2'b00,
    PMS_ADC_SAMPLE = 2'b01,
    PMS_ADC_TEMP = 2'b10
} pms_adc_st_t;

typedef enum logic [1:0] {
    PMS_HST_IDLE = 2'b00,
    PMS_HST_LOW = 2'b01,
    PMS_HST_HIGH = 2'b10,
    PMS_HST_GAP = 2'b11
} pms_hst_st_t;

typedef struct packed {
    logic cont;
    logic [2:0] avg_n;
    logic [1:0] vsel;
    logic conv_pend;
    pms_adc_st_t st;
    logic adc_req;
    logic adc_temp;
    logic [7:0] n_cnt;
    logic signed [22:0] sum_i;
    logic [22:0] sum_v;
    logic [22:0] sum_o;
    logic signed [38:0] sum_p;
    logic [15:0] res_i;
    logic [15:0] res_v;
    logic [15:0] res_o;
    logic [31:0] res_p;
    logic [15:0] res_t;
    logic [31:0] energy;
    logic [23:0] e_cnt;
    logic [7:0] e_roll;
    logic [23:0] snap_cnt;
    logic [15:0] pk_i;
    logic [15:0] pk_v;
    logic [15:0] pk_o;
    logic [31:0] pk_p;
    logic [15:0] pk_t;
    logic [79:0] frame_cur;
    logic [79:0] frame_prev;
    logic [79:0] frame_sh;
    logic [6:0] bits_left;
    logic active;
    logic dout;
    logic oe;
    logic sel_s1;
    logic sel_s2;
    logic sel_s3;
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic [23:0] tmr;
    logic temp_due;
    logic temp_phase;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
} pms_dev_state_t;

typedef struct packed {
    pms_hst_st_t st;
    logic [15:0] cnt;
    logic [6:0] bits;
    logic [6:0] nbits;
    logic sel_n;
    logic sclk;
    logic [79:0] shreg;
    logic [79:0] rx;
    logic din_s1;
    logic din_s2;
    logic start_pend;
    logic done;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
} pms_hst_state_t;

endpackage : pms_pkg

// >>> core/pms_link_if.sv
`timescale 1ns/100ps
interface pms_link_if;
    logic serial_select_n;
    logic serial_shift_clock;
    logic serial_data_out;
    logic serial_data_oe;

    modport device (
        input serial_select_n,
        input serial_shift_clock,
        output serial_data_out,
        output serial_data_oe
    );

    modport host (
        output serial_select_n,
        output serial_shift_clock,
        input serial_data_out,
        input serial_data_oe
    );
endinterface : pms_link_if

// >>> core/pms_host.sv
`timescale 1ns/100ps
`include "pms_defines.svh"
module pms_host #(
    parameter int HALF_CYC = `PMS_SCLK_HALF_CYC,
    parameter int GAP_CYC = `PMS_FRAME_GAP_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Command registers
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Stream link
    pms_link_if.host link
);

    pms_pkg::pms_hst_state_t r_reg;
    pms_pkg::pms_hst_state_t r_next;

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign link.serial_select_n = r_reg.sel_n;
    assign link.serial_shift_clock = r_reg.sclk;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic busy;
        logic done_set;
        busy = 1'b0;
        done_set = 1'b0;
        r_next = r_reg;
        r_next.pready = 1'b1;
        r_next.din_s1 = link.serial_data_out;
        r_next.din_s2 = r_reg.din_s1;
        busy = (r_reg.st != pms_pkg::PMS_HST_IDLE) || r_reg.start_pend;

        case (r_reg.st)
            pms_pkg::PMS_HST_IDLE: begin
                if (r_reg.start_pend) begin
                    r_next.start_pend = 1'b0;
                    r_next.sel_n = 1'b0;
                    r_next.sclk = 1'b0;
                    r_next.bits = 7'h00;
                    r_next.shreg = '0;
                    r_next.cnt = 16'(HALF_CYC - 1);
                    r_next.st = pms_pkg::PMS_HST_LOW;
                end
            end
            pms_pkg::PMS_HST_LOW: begin
                if (r_reg.cnt == 16'h0000) begin
                    // Mode 0: capture on the rising edge
                    r_next.sclk = 1'b1;
                    r_next.shreg = {r_reg.shreg[`PMS_FRAME_BITS - 2:0], r_reg.din_s2};
                    r_next.bits = r_reg.bits + 7'h01;
                    r_next.cnt = 16'(HALF_CYC - 1);
                    r_next.st = pms_pkg::PMS_HST_HIGH;
                end else begin
                    r_next.cnt = r_reg.cnt - 16'h0001;
                end
            end
            pms_pkg::PMS_HST_HIGH: begin
                if (r_reg.cnt == 16'h0000) begin
                    r_next.cnt = 16'(HALF_CYC - 1);
                    if (r_reg.bits == r_reg.nbits) begin
                        // Short counts end the frame early
                        r_next.sel_n = 1'b1;
                        r_next.rx = r_reg.shreg;
                        done_set = 1'b1;
                        r_next.cnt = 16'(GAP_CYC - 1);
                        r_next.st = pms_pkg::PMS_HST_GAP;
                    end else begin
                        r_next.sclk = 1'b0;
                        r_next.st = pms_pkg::PMS_HST_LOW;
                    end
                end else begin
                    r_next.cnt = r_reg.cnt - 16'h0001;
                end
            end
            pms_pkg::PMS_HST_GAP: begin
                r_next.sclk = 1'b0;
                if (r_reg.cnt == 16'h0000) begin
                    r_next.st = pms_pkg::PMS_HST_IDLE;
                end else begin
                    r_next.cnt = r_reg.cnt - 16'h0001;
                end
            end
            default: r_next.st = pms_pkg::PMS_HST_IDLE;
        endcase

        ////////////////////////////////////////////////////////////////////////
        if (psel && !penable) begin
            r_next.pslverr = 1'b0;
            case (paddr)
                `PMS_HST_CONTROL: r_next.prdata = {17'h0, r_reg.nbits, 8'h00};
                `PMS_HST_STATUS: r_next.prdata = {30'h0, r_reg.done, busy};
                `PMS_HST_RX0: r_next.prdata = r_reg.rx[31:0];
                `PMS_HST_RX1: r_next.prdata = r_reg.rx[63:32];
                `PMS_HST_RX2: r_next.prdata = {16'h0, r_reg.rx[79:64]};
                default: begin
                    r_next.prdata = 32'h0000_0000;
                    r_next.pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && pwrite) begin
            if (paddr == `PMS_HST_CONTROL) begin
                r_next.nbits = pwdata[`PMS_HCTL_NBITS_LO +: 7];
                if (pwdata[`PMS_HCTL_START] && pwdata[`PMS_HCTL_NBITS_LO +: 7] != 7'h00) begin
                    r_next.start_pend = 1'b1;
                end
            end
            if (paddr == `PMS_HST_STATUS && pwdata[`PMS_HST_DONE]) begin
                r_next.done = 1'b0;
            end
        end
        // A frame ending in the clearing cycle still counts
        if (done_set) begin
            r_next.done = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.sel_n <= 1'b1;
            r_reg.nbits <= 7'(`PMS_FRAME_BITS);
        end else begin
            r_reg <= r_next;
        end
    end

endmodule : pms_host

// >>> verif/pms_assertions.sv
`timescale 1ns/100ps
module pms_assertions (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Stream link
    input wire logic serial_select_n,
    input wire logic serial_shift_clock,
    input wire logic serial_data_out,
    input wire logic serial_data_oe
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Clock falls seen within the current frame
    logic [6:0] falls;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            falls <= 7'h0;
        end else if (serial_select_n) begin
            falls <= 7'h0;
        end else if ($fell(serial_shift_clock)) begin
            falls <= falls + 7'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    hiz_idle_a: assert property (serial_select_n [*6] |-> !serial_data_oe)
        else $error("data driven while deselected");
    frame_hold_a: assert property ((!serial_select_n [*6]) ##0 (falls < 7'd80) |-> serial_data_oe)
        else $error("data released inside frame");
    abort_stop_a: assert property ($rose(serial_select_n) |-> ##[1:6] !serial_data_oe)
        else $error("no release after select rise");
    first_bit_a: assert property ($fell(serial_select_n) |-> ##[2:6] serial_data_oe)
        else $error("first bit late");
    high_stable_a: assert property (serial_shift_clock && $past(serial_shift_clock) && serial_data_oe
        && $past(serial_data_oe) |-> $stable(serial_data_out))
        else $error("data moved while clock high");
    sel_gates_oe_a: assert property ($rose(serial_data_oe) |-> !serial_select_n && !$past(serial_select_n, 2))
        else $error("drive without select");
    clk_idle_a: assert property (serial_select_n [*3] |-> !serial_shift_clock)
        else $error("clock moves while deselected");
    clk_half_a: assert property ($rose(serial_shift_clock) |-> serial_shift_clock [*8])
        else $error("clock high too short");
    cover property ($fell(serial_select_n));
    cover property ($rose(serial_select_n) && falls < 7'd20);
    cover property (falls == 7'd79);
endmodule : pms_assertions

// >>> verif/test_power_monitor_stream_out.sv
`timescale 1ns/100ps
module test_power_monitor_stream_out;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ps_d = 1'b0, ps_h = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd_d, rd_h, rd;
    logic rdy_d, rdy_h, er_d, er_h, err;
    logic adc_req, adc_temp, adc_done = 1'b0, alt = 1'b0, avg_on = 1'b0;
    logic [15:0] ci = 16'h8123, vi = 16'h1234, vo = 16'h0f0f;
    logic signed [31:0] pw;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    pms_link_if link_i();
    always #10 pclk = ~pclk;
    // ADC answers next cycle; toggle gives alternating voltage for averaging
    always @(posedge pclk) begin
        adc_done <= adc_req;
        alt <= alt ^ (adc_done & ~adc_temp & avg_on);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end
    pms_device #(.TEMP_PERIOD_CYC(200)) pms_device_inst (.pclk(pclk), .presetn(presetn), .psel(ps_d),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rd_d), .pready(rdy_d),
        .pslverr(er_d), .adc_req(adc_req), .adc_temp(adc_temp), .adc_done(adc_done), .adc_current(ci),
        .adc_vin(vi + {14'h0, avg_on & alt, 1'b0}), .adc_output_voltage_pin(vo), .adc_temperature(16'h0055),
        .link(link_i.device));
    pms_host #(.HALF_CYC(25), .GAP_CYC(50)) pms_host_inst (.pclk(pclk), .presetn(presetn), .psel(ps_h),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rd_h), .pready(rdy_h),
        .pslverr(er_h), .link(link_i.host));
    pms_assertions pms_assertions_inst (.pclk(pclk), .presetn(presetn),
        .serial_select_n(link_i.serial_select_n), .serial_shift_clock(link_i.serial_shift_clock),
        .serial_data_out(link_i.serial_data_out), .serial_data_oe(link_i.serial_data_oe));
    ////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Idle cycle first, so strobes are never assigned twice in one step
    task automatic bus(input logic h, input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        ps_h <= h;
        ps_d <= ~h;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while ((h ? rdy_h : rdy_d) !== 1'b1);
        rd = h ? rd_h : rd_d;
        err = h ? er_h : er_d;
        ps_h <= 1'b0;
        ps_d <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic conv(input logic [31:0] cfg);
        bus(1'b0, 1'b1, 8'h00, cfg);
        bus(1'b0, 1'b1, 8'h04, 32'h1);
        do bus(1'b0, 1'b0, 8'h04, 32'h0); while (rd[0] !== 1'b0);
    endtask : conv
    task automatic frame(input logic [6:0] n);
        bus(1'b1, 1'b1, 8'h00, {17'h0, n, 8'h01});
        do bus(1'b1, 1'b0, 8'h04, 32'h0); while (rd[1] !== 1'b1);
        bus(1'b1, 1'b1, 8'h04, 32'h2);
    endtask : frame
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        bus(1'b1, 1'b0, 8'h00, 32'h0);
        chk(rd, 32'h00005000);
        bus(1'b0, 1'b0, 8'h3c, 32'h0);
        chk({31'h0, err}, 32'h1);
        pw = $signed(ci) * $signed({1'b0, vi[14:0]});
        conv(32'h30);
        bus(1'b0, 1'b0, 8'h08, 32'h0);
        chk(rd, 32'hffff8123);
        bus(1'b0, 1'b0, 8'h14, 32'h0);
        chk(rd, pw);
        bus(1'b0, 1'b0, 8'h18, 32'h0);
        chk(rd, pw);
        bus(1'b0, 1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h1);
        ci <= 16'h1357;
        vi <= 16'h2468;
        vo <= 16'h0abc;
        frame(7'd80);
        frame(7'd80);
        bus(1'b1, 1'b0, 8'h10, 32'h0);
        chk(rd, 32'h00008123);
        bus(1'b1, 1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h12340f0f);
        bus(1'b0, 1'b0, 8'h18, 32'h0);
        bus(1'b0, 1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h3);
        frame(7'd8);
        bus(1'b1, 1'b0, 8'h08, 32'h0);
        chk({24'h0, rd[7:0]}, 32'h13);
        avg_on <= 1'b1;
        conv(32'h32);
        bus(1'b0, 1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h2469);
        bus(1'b0, 1'b0, 8'h24, 32'h0);
        chk(rd, 32'h1357);
        bus(1'b0, 1'b0, 8'h38, 32'h0);
        chk(rd, 32'h55);
        ci <= 16'h0246;
        bus(1'b0, 1'b1, 8'h00, 32'h31);
        repeat (20) @(posedge pclk);
        bus(1'b0, 1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0246);
        complete_run();
    end
endmodule : test_power_monitor_stream_out
